// *** rtl/mux_pixel_input_unpacker.sv ***
// multiplexed 12-bit pixel bus unpacker with embedded timing decode
//
// Contract
// - format 0 word layout, 12-12 scheme one
// - format 1 word layout, 12-12 scheme two
// - format 2 word layout, 5-6-5
// - format 3 word layout, 5-5-5, second word bit 11 ignored
// - format 4: chroma first, luma second, low zero
// - format 4 accepts embedded timing codes
// - timing code is FF 00 00 status, Cb-aligned
// - status bit 6 gives the field
// - status bit 5 gives vertical blanking
// - status bit 4 marks end versus start
// - other status bits are ignored
// - first word after sync lead is first half
// - 1X latches both edges, 2X one edge
`default_nettype none
module mux_pixel_input_unpacker
    import mux_pixel_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    input  wire logic              pixel_clock_in,
    input  wire logic [BUS_W-1:0]  pixel_bus_in,
    input  wire logic              data_enable_in,
    input  wire logic              line_sync_in,
    input  wire logic [FMT_W-1:0]  input_format_select_in,
    input  wire logic              clock_double_in,
    input  wire logic              clock_invert_in,
    input  wire logic              embedded_sync_en_in,
    output logic      [PIX_W-1:0]  pixel_out,
    output logic                   pixel_valid_out,
    output logic                   data_enable_out,
    output logic                   chroma_phase_out,
    output logic                   field_out,
    output logic                   vblank_out,
    output logic                   line_end_out,
    output logic                   timing_code_out
);
    // ========================================
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ========================================
    // state
    typedef struct packed {
        logic                    clk_s1;
        logic                    clk_s2;
        logic                    clk_s3;
        logic [BUS_W-1:0]        dat_s1;
        logic [BUS_W-1:0]        dat_s2;
        logic [BUS_W-1:0]        dat_s3;
        logic                    de_s1;
        logic                    de_s2;
        logic                    de_s3;
        logic                    hs_s1;
        logic                    hs_s2;
        logic                    hs_s3;
        logic [FMT_W-1:0]        fmt_s1;
        logic [FMT_W-1:0]        fmt_s2;
        logic                    dbl_s1;
        logic                    dbl_s2;
        logic                    inv_s1;
        logic                    inv_s2;
        logic                    emb_s1;
        logic                    emb_s2;
        logic                    phase;
        logic [BUS_W-1:0]        word_a;
        logic [BUS_W-1:0]        word_b;
        logic                    de_a;
        logic [2:0][BYTE_W-1:0]  hist;
        logic                    chroma_next;
        logic [PIX_W-1:0]        pixel;
        logic                    valid;
        logic                    de_q;
        logic                    chroma_q;
        logic                    field;
        logic                    vblank;
        logic                    line_end;
        logic                    trc;
    } state_t;

    state_t st;
    state_t next_st;

    // ========================================
    // word pair to 24-bit pixel
    function automatic logic [PIX_W-1:0] unpack(
        input logic [BUS_W-1:0] a,
        input logic [BUS_W-1:0] b,
        input logic [FMT_W-1:0] fmt
    );
        logic [PIX_W-1:0] p;
        p = '0;
        unique case (fmt)
            FMT_RGB_A: begin
                p = {b[11:4], b[3:0], a[11:8], a[7:0]};
            end
            FMT_RGB_B: begin
                p = {b[11:7], b[3:1], b[6:4], a[11:9], b[0], a[3],
                     a[8:4], a[2:0]};
            end
            FMT_RGB_565: begin
                p = {b[11:7], 3'h0, b[6:4], a[11:9], 2'h0,
                     a[8:4], 3'h0};
            end
            FMT_RGB_555: begin
                p = {b[10:6], 3'h0, b[5:4], a[11:9], 3'h0,
                     a[8:4], 3'h0};
            end
            FMT_YCRCB: begin
                p = {b[7:0], a[7:0], 8'h00};
            end
            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction : unpack

    // ========================================
    // edge detection and word latching
    logic rise;
    logic fall;
    logic lead;
    logic latch;
    logic hs_lead;
    logic ph;
    logic is_trc;

    always_comb begin
        next_st = st;
        next_st.clk_s1 = pixel_clock_in;
        next_st.clk_s2 = st.clk_s1;
        next_st.clk_s3 = st.clk_s2;
        next_st.dat_s1 = pixel_bus_in;
        next_st.dat_s2 = st.dat_s1;
        next_st.dat_s3 = st.dat_s2;
        next_st.de_s1  = data_enable_in;
        next_st.de_s2  = st.de_s1;
        next_st.de_s3  = st.de_s2;
        next_st.hs_s1  = line_sync_in;
        next_st.hs_s2  = st.hs_s1;
        next_st.hs_s3  = st.hs_s2;
        next_st.fmt_s1 = input_format_select_in;
        next_st.fmt_s2 = st.fmt_s1;
        next_st.dbl_s1 = clock_double_in;
        next_st.dbl_s2 = st.dbl_s1;
        next_st.inv_s1 = clock_invert_in;
        next_st.inv_s2 = st.inv_s1;
        next_st.emb_s1 = embedded_sync_en_in;
        next_st.emb_s2 = st.emb_s1;
        next_st.valid  = 1'b0;
        next_st.trc    = 1'b0;

        rise    = st.clk_s2 & ~st.clk_s3;
        fall    = ~st.clk_s2 & st.clk_s3;
        lead    = st.inv_s2 ? fall : rise;
        latch   = st.dbl_s2 ? lead : (rise | fall);
        hs_lead = st.hs_s2 & ~st.hs_s3;
        ph      = hs_lead ? 1'b0 : st.phase;
        is_trc  = st.emb_s2 && (st.fmt_s2 == FMT_YCRCB) && ph
                  && (st.hist[2] == TRC_PREAMBLE_1)
                  && (st.hist[1] == TRC_PREAMBLE_0)
                  && (st.hist[0] == TRC_PREAMBLE_0);

        if (hs_lead) begin
            next_st.phase       = 1'b0;
            next_st.chroma_next = 1'b0;
        end
        if (latch) begin
            // bus sampled just before the edge was seen
            next_st.hist = {st.hist[1:0], st.dat_s3[BYTE_W-1:0]};
            if (!ph) begin
                next_st.word_a = st.dat_s3;
                next_st.de_a   = st.de_s3;
                next_st.phase  = 1'b1;
            end else begin
                next_st.word_b = st.dat_s3;
                next_st.phase  = 1'b0;
                if (is_trc) begin
                    next_st.trc         = 1'b1;
                    next_st.field    = st.dat_s3[STAT_FIELD];
                    next_st.vblank   = st.dat_s3[STAT_VBLANK];
                    next_st.line_end = st.dat_s3[STAT_EAV];
                    next_st.chroma_next = 1'b0;
                end else begin
                    next_st.pixel    = unpack(st.word_a, st.dat_s3,
                                              st.fmt_s2);
                    next_st.valid    = 1'b1;
                    next_st.de_q     = st.de_a;
                    next_st.chroma_q = st.chroma_next;
                    next_st.chroma_next = ~st.chroma_next;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pixel_out        = st.pixel;
    assign pixel_valid_out  = st.valid;
    assign data_enable_out  = st.de_q;
    assign chroma_phase_out = st.chroma_q;
    assign field_out        = st.field;
    assign vblank_out       = st.vblank;
    assign line_end_out     = st.line_end;
    assign timing_code_out  = st.trc;

    // ========================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    fmt0_layout_a: assert property (st.valid && st.fmt_s2 == FMT_RGB_A
        |-> st.pixel[23:16] == st.word_b[11:4]
            && st.pixel[15:12] == st.word_b[3:0])
        else $error("format 0 layout wrong");
    fmt1_layout_a: assert property (st.valid && st.fmt_s2 == FMT_RGB_B
        |-> st.pixel[7:0] == {st.word_a[8:4], st.word_a[2:0]}
            && st.pixel[9] == st.word_b[0])
        else $error("format 1 layout wrong");
    fmt2_zero_a: assert property (st.valid && st.fmt_s2 == FMT_RGB_565
        |-> st.pixel[18:16] == 3'h0 && st.pixel[9:8] == 2'h0
            && st.pixel[23:19] == st.word_b[11:7])
        else $error("format 2 layout wrong");
    fmt3_layout_a: assert property (st.valid && st.fmt_s2 == FMT_RGB_555
        |-> st.pixel[23:19] == st.word_b[10:6]
            && st.pixel[10:8] == 3'h0)
        else $error("format 3 layout wrong");
    ycc_low_zero_a: assert property (st.valid && st.fmt_s2 == FMT_YCRCB
        |-> st.pixel[7:0] == 8'h00
            && st.pixel[15:8] == st.word_a[7:0])
        else $error("format 4 layout wrong");
    trc_status_a: assert property (st.trc
        |-> field_out == st.word_b[STAT_FIELD]
            && vblank_out == st.word_b[STAT_VBLANK]
            && line_end_out == st.word_b[STAT_EAV])
        else $error("status flags not from status byte");
    trc_pattern_a: assert property (st.trc
        |-> st.hist[1] == TRC_PREAMBLE_0 && st.hist[2] == TRC_PREAMBLE_0
            && st.hist[0] == st.word_b[7:0] && !st.valid)
        else $error("timing code without preamble");
    sync_phase_a: assert property (st.hs_s2 && !st.hs_s3
        |=> !st.phase || st.word_a == $past(st.dat_s3))
        else $error("sync lead did not restart pair");
    single_edge_a: assert property (st.dbl_s2 && $stable(st.dbl_s2)
        && st.valid |=> !st.valid [*3])
        else $error("2X mode paired too fast");

    pix_rgb_c: cover property (st.valid && st.fmt_s2 == FMT_RGB_A);
    pix_ycc_c: cover property (st.valid && st.fmt_s2 == FMT_YCRCB);
    trc_seen_c: cover property (st.trc && line_end_out);
endmodule : mux_pixel_input_unpacker
`default_nettype wire

// *** rtl/mux_pixel_pkg.sv ***
// constants for the multiplexed pixel input unpacker
`default_nettype none
package mux_pixel_pkg;
    // ========================================
    // bus and pixel widths
    localparam int BUS_W   = 12;
    localparam int PIX_W   = 24;
    localparam int BYTE_W  = 8;
    localparam int FMT_W   = 3;
    // ========================================
    // input format select codes
    localparam logic [FMT_W-1:0] FMT_RGB_A    = 3'h0;
    localparam logic [FMT_W-1:0] FMT_RGB_B    = 3'h1;
    localparam logic [FMT_W-1:0] FMT_RGB_565  = 3'h2;
    localparam logic [FMT_W-1:0] FMT_RGB_555  = 3'h3;
    localparam logic [FMT_W-1:0] FMT_YCRCB    = 3'h4;
    // ========================================
    // embedded timing reference code
    localparam logic [BYTE_W-1:0] TRC_PREAMBLE_1 = 8'hFF;
    localparam logic [BYTE_W-1:0] TRC_PREAMBLE_0 = 8'h00;
    localparam int STAT_FIELD  = 6;
    localparam int STAT_VBLANK = 5;
    localparam int STAT_EAV    = 4;
endpackage : mux_pixel_pkg
`default_nettype wire

// *** dv/ctrl_model.sv ***
// graphics controller model driving the multiplexed pixel bus
`default_nettype none
module ctrl_model
    import mux_pixel_pkg::*;
(
    input  wire logic             dbl_in,
    input  wire logic             inv_in,
    output logic                  pclk_out,
    output logic      [BUS_W-1:0] bus_out,
    output logic                  de_out,
    output logic                  sync_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pclk_out = 1'b0;
        bus_out  = '0;
        de_out   = 1'b0;
        sync_out = 1'b0;
    end
    // =======================================
    // link tasks
    task automatic park();
        if (dbl_in) pclk_out = inv_in;
        #64;
    endtask : park
    task automatic line_sync();
        sync_out = 1'b1;
        #32;
        sync_out = 1'b0;
    endtask : line_sync
    task automatic word(input logic [BUS_W-1:0] w, input logic de);
        bus_out = w;
        de_out  = de;
        #32;
        pclk_out = dbl_in ? ~inv_in : ~pclk_out;
        #32;
        if (dbl_in) pclk_out = inv_in;
    endtask : word
    task automatic blank(input logic ycc);
        word(ycc ? 12'h080 : 12'h000, 1'b0);
        word(ycc ? 12'h010 : 12'h000, 1'b0);
    endtask : blank
    task automatic release_bus();
        bus_out = ~bus_out;
        de_out  = 1'b0;
    endtask : release_bus
endmodule : ctrl_model
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench for the multiplexed pixel input unpacker
`default_nettype none
module tb_top
    import mux_pixel_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in, resetn_in, pclk, de, lsync, dbl, inv, emb;
    logic [BUS_W-1:0] bus;
    logic [FMT_W-1:0] fmt;
    logic [PIX_W-1:0] pixel_out;
    logic pv, de_o, cph, fld, vbl, lend, tc;
    logic [25:0] pq[$];
    int failures, comparisons, tcodes;
    mux_pixel_input_unpacker DUT (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .pixel_clock_in(pclk), .pixel_bus_in(bus), .data_enable_in(de),
        .line_sync_in(lsync), .input_format_select_in(fmt),
        .clock_double_in(dbl), .clock_invert_in(inv),
        .embedded_sync_en_in(emb), .pixel_out(pixel_out),
        .pixel_valid_out(pv), .data_enable_out(de_o),
        .chroma_phase_out(cph), .field_out(fld), .vblank_out(vbl),
        .line_end_out(lend), .timing_code_out(tc));
    ctrl_model u_ctrl (.dbl_in(dbl), .inv_in(inv), .pclk_out(pclk),
        .bus_out(bus), .de_out(de), .sync_out(lsync));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (pv === 1'b1) pq.push_back({de_o, cph, pixel_out});
        if (tc === 1'b1) tcodes++;
    end
    // =======================================
    // checking helpers
    function automatic logic [PIX_W-1:0] rgb(int f, logic [11:0] a, b);
        case (f)
            0: return {b, a};
            1: return {b[11:7], b[3:1], b[6:4], a[11:9], b[0], a[3],
                       a[8:4], a[2:0]};
            2: return {b[11:7], 3'h0, b[6:4], a[11:9], 2'h0,
                       a[8:4], 3'h0};
            3: return {b[10:6], 3'h0, b[5:4], a[11:9], 3'h0,
                       a[8:4], 3'h0};
            4: return {b[7:0], a[7:0], 8'h00};
            default: return '0;
        endcase
    endfunction : rgb
    task automatic cmp_cnt(input logic [31:0] got,
                           input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_cnt
    task automatic take(input logic [25:0] exp, input bit use_c);
        logic [25:0] got;
        got = pq.pop_front();
        if (!use_c) got[24] = exp[24];
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : take
    task automatic pair(input logic [11:0] a, b, input logic d);
        u_ctrl.word(a, d);
        u_ctrl.word(b, d);
    endtask : pair
    task automatic flush(input int n);
        u_ctrl.release_bus();
        repeat (12) @(posedge mclk_in);
        #1;
        cmp_cnt(pq.size(), n);
        if (pq.size() != n) pq.delete();
    endtask : flush
    task automatic mode(input logic [2:0] f, input logic d, i, e);
        fmt = f;
        dbl = d;
        inv = i;
        emb = e;
        u_ctrl.park();
        u_ctrl.line_sync();
    endtask : mode
    // =======================================
    // scenarios
    task automatic test_rgb();
        logic [11:0] a, b;
        for (int f = 0; f < 8; f++) begin
            mode(f[2:0], 1'b1, 1'b0, 1'b0);
            a = 12'hA5C ^ f[11:0];
            b = 12'hBE1 + f[11:0];
            pair(a, b, f != 3);
            flush(1);
            if (pq.size() == 1)
                take({f != 3, 1'b0, rgb(f, a, b)}, 0);
        end
        $display("test_rgb done");
    endtask : test_rgb
    task automatic test_clk();
        for (int k = 0; k < 2; k++) begin
            mode(3'h0, k[0], k[0], 1'b0);
            pair(12'h9C3, 12'h6B2, 1'b1);
            pair(12'h1E7, 12'hD48, 1'b1);
            flush(2);
            if (pq.size() == 2) begin
                take({2'b10, rgb(0, 12'h9C3, 12'h6B2)}, 0);
                take({2'b10, rgb(0, 12'h1E7, 12'hD48)}, 0);
            end
        end
        $display("test_clk done");
    endtask : test_clk
    task automatic test_ycc();
        mode(3'h4, 1'b1, 1'b0, 1'b0);
        pair(12'hF40, 12'hF51, 1'b1);
        pair(12'hF62, 12'hF73, 1'b1);
        u_ctrl.blank(1'b1);
        flush(3);
        if (pq.size() == 3) begin
            take({2'b10, 8'h51, 8'h40, 8'h00}, 1);
            take({2'b11, 8'h73, 8'h62, 8'h00}, 1);
            take({2'b00, 8'h10, 8'h80, 8'h00}, 1);
        end
        $display("test_ycc done");
    endtask : test_ycc
    task automatic test_trc();
        logic [7:0] st;
        for (int k = 0; k < 2; k++) begin
            st = k ? 8'h2F : 8'hDF;
            mode(3'h4, 1'b1, 1'b0, 1'b1);
            pair({4'h0, TRC_PREAMBLE_1}, {4'h0, TRC_PREAMBLE_0}, 1'b0);
            pair({4'h0, TRC_PREAMBLE_0}, {4'h0, st}, 1'b0);
            pair(12'h010, 12'h0EB, 1'b1);
            flush(2);
            if (pq.size() == 2) begin
                take({2'b00, 8'h00, 8'hFF, 8'h00}, 1);
                take({2'b10, 8'hEB, 8'h10, 8'h00}, 1);
            end
            cmp_cnt(tcodes, k + 1);
            cmp_cnt(fld, st[6]);
            cmp_cnt(vbl, st[5]);
            cmp_cnt(lend, st[4]);
        end
        $display("test_trc done");
    endtask : test_trc
    task automatic summarize();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    initial begin
        resetn_in = 1'b0;
        {fmt, dbl, inv, emb} = '0;
        repeat (6) @(posedge mclk_in);
        #1 resetn_in = 1'b1;
        repeat (4) @(posedge mclk_in);
        #1;
        test_rgb();
        test_clk();
        test_ycc();
        test_trc();
        summarize();
    end
    initial begin
        #100us;
        failures++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
